// ==== hdl/bmsi_defines.vh ====
`ifndef BMSI_DEFINES_VH
`define BMSI_DEFINES_VH
`define BMSI_MODE_PLAY 2'h0
`define BMSI_MODE_SPI 2'h1
`define BMSI_MODE_MIDI 2'h2
`define BMSI_CLK_HZ 200000000
`define BMSI_SPI_HZ 3987630
`define BMSI_SPI_HALF 6'h19
`define BMSI_SIG0 8'h50
`define BMSI_SIG1 8'h26
`define BMSI_SIG2 8'h48
`define BMSI_RD_CMD 8'h03
`define BMSI_MIDI_PREFIX 8'hff
`define BMSI_RATE_MIDI 16'hac44
`define BMSI_MULT_MIDI 4'h8
`define BMSI_UART_MIDI 16'h7a12
`define BMSI_ZERO_RUN 12'h804
`define BMSI_PTR_ADC 16'hc01e
`define BMSI_WIN_ADC 16'h0800
`define BMSI_FIFO_W 8
`define BMSI_FIFO_D 8
`endif

// ==== hdl/bmsi_fifo.v ====
`timescale 1ns/1ps
module bmsi_fifo #(
  parameter W = 8,
  parameter D = 8,
  parameter AW = 3
) (
  input wire mclk,
  input wire rst,
  input wire [W-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [W-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [W-1:0] mem [0:D-1];
  reg [AW:0] wp_q;
  reg [AW:0] rp_q;
  wire full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  wire empty = wp_q == rp_q;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rp_q[AW-1:0]];
  always @(posedge mclk) begin
    if (in_valid && !full) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      wp_q <= {(AW+1){1'b0}};
      rp_q <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full) begin
        wp_q <= wp_q + 1'b1;
      end
      if (out_ready && !empty) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule

// ==== hdl/bmsi_top.v ====
`timescale 1ns/1ps
`include "bmsi_defines.vh"
module bmsi_top #(
  parameter ADDR24 = 1'b0
) (
  input wire mclk,
  input wire rst,
  input wire sw_reset,
  input wire boot_select_pin_a_i,
  output reg boot_select_pin_a_o,
  output reg boot_select_pin_a_oe,
  input wire boot_select_pin_b_i,
  output reg boot_select_pin_b_o,
  output reg boot_select_pin_b_oe,
  input wire general_pin_c,
  input wire general_pin_d,
  output reg data_request,
  input wire sdi_clk,
  input wire serial_data_input,
  input wire [7:0] uart_byte,
  input wire uart_valid,
  input wire decodable,
  input wire reg_wr,
  input wire reg_sel_window,
  input wire [15:0] reg_wdata,
  output reg [1:0] mode_q,
  output reg boot_done_q,
  output reg boot_fail_q,
  output reg [15:0] sample_rate_q,
  output reg [3:0] clock_mult_q,
  output reg [15:0] uart_rate_q,
  output reg [1:0] spatial_q,
  output reg [7:0] midi_byte_q,
  output reg midi_valid_q,
  output reg [7:0] stream_byte_q,
  output reg stream_valid_q,
  input wire stream_ready,
  output reg [15:0] header_data_word0,
  output reg [15:0] header_data_word1,
  output reg mute_q,
  output reg idle_q,
  output reg stream_end_q,
  output reg adc_on_q
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  reg [1:0] a_s_q, b_s_q, c_s_q, d_s_q, miso_s_q, sck_s_q, sdi_s_q;
  wire fifo_in_ready;
  wire [7:0] fifo_data;
  wire fifo_valid;
  wire fifo_pop;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      a_s_q <= 2'h0;
      b_s_q <= 2'h0;
      c_s_q <= 2'h0;
      d_s_q <= 2'h0;
      miso_s_q <= 2'h0;
      sck_s_q <= 2'h0;
      sdi_s_q <= 2'h0;
    end else begin
      a_s_q <= {a_s_q[0], boot_select_pin_a_i};
      b_s_q <= {b_s_q[0], boot_select_pin_b_i};
      c_s_q <= {c_s_q[0], general_pin_c};
      d_s_q <= {d_s_q[0], general_pin_d};
      miso_s_q <= {miso_s_q[0], general_pin_c};
      sck_s_q <= {sck_s_q[0], sdi_clk};
      sdi_s_q <= {sdi_s_q[0], serial_data_input};
    end
  end
  // ****************************************
  // boot strap sampling and mode
  // ****************************************
  // four cycles let the synchronisers fill before sampling
  reg [1:0] strap_cnt_q;
  reg strap_done_q;
  localparam S_IDLE = 3'h0, S_CMD = 3'h1, S_SIG = 3'h2, S_DONE = 3'h3;
  reg [2:0] st_q;
  reg [5:0] div_q;
  reg [5:0] bit_q;
  reg [31:0] sh_q;
  reg [23:0] sig_q;
  reg sck_q;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      strap_cnt_q <= 2'h0;
      strap_done_q <= 1'b0;
      mode_q <= `BMSI_MODE_PLAY;
      spatial_q <= 2'h0;
      sample_rate_q <= 16'h0;
      clock_mult_q <= 4'h0;
      uart_rate_q <= 16'h0;
      boot_done_q <= 1'b0;
      boot_fail_q <= 1'b0;
      st_q <= S_IDLE;
      div_q <= 6'h0;
      bit_q <= 6'h0;
      sh_q <= 32'h0;
      sig_q <= 24'h0;
      sck_q <= 1'b0;
      boot_select_pin_a_o <= 1'b1;
      boot_select_pin_a_oe <= 1'b0;
      boot_select_pin_b_o <= 1'b0;
      boot_select_pin_b_oe <= 1'b0;
    end else begin
      if (!strap_done_q) begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
        if (strap_cnt_q == 2'h3) begin
          strap_done_q <= 1'b1;
          spatial_q <= {d_s_q[1], c_s_q[1]};
          if (a_s_q[1]) begin
            mode_q <= `BMSI_MODE_SPI;
            st_q <= S_CMD;
            boot_select_pin_a_oe <= 1'b1;
            boot_select_pin_b_oe <= 1'b1;
            boot_select_pin_a_o <= 1'b0;
            sh_q <= {`BMSI_RD_CMD, 24'h0};
            bit_q <= ADDR24 ? 6'h20 : 6'h18;
          end else if (b_s_q[1]) begin
            mode_q <= `BMSI_MODE_MIDI;
            sample_rate_q <= `BMSI_RATE_MIDI;
            clock_mult_q <= `BMSI_MULT_MIDI;
            uart_rate_q <= `BMSI_UART_MIDI;
            boot_done_q <= 1'b1;
          end else begin
            mode_q <= `BMSI_MODE_PLAY;
            boot_done_q <= 1'b1;
          end
        end
      end else if (st_q == S_CMD || st_q == S_SIG) begin
        // spi master, half period from the 3987630 Hz figure
        if (div_q == `BMSI_SPI_HALF) begin
          div_q <= 6'h0;
          sck_q <= !sck_q;
          boot_select_pin_b_o <= !sck_q;
          if (sck_q) begin
            sh_q <= {sh_q[30:0], 1'b0};
            bit_q <= bit_q - 6'h1;
            if (bit_q == 6'h1) begin
              if (st_q == S_CMD) begin
                st_q <= S_SIG;
                bit_q <= 6'h18;
              end else begin
                st_q <= S_DONE;
                boot_select_pin_a_o <= 1'b1;
              end
            end
          end else if (st_q == S_SIG) begin
            sig_q <= {sig_q[22:0], miso_s_q[1]};
          end
        end else begin
          div_q <= div_q + 6'h1;
        end
      end else if (st_q == S_DONE) begin
        boot_done_q <= 1'b1;
        boot_fail_q <= sig_q != {`BMSI_SIG0, `BMSI_SIG1, `BMSI_SIG2};
        boot_select_pin_a_oe <= 1'b0;
        boot_select_pin_b_oe <= 1'b0;
        st_q <= S_IDLE;
      end
    end
  end
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      data_request <= 1'b0;
    end else if (st_q == S_CMD || st_q == S_SIG) begin
      data_request <= sh_q[31];
    end else begin
      data_request <= boot_done_q && fifo_in_ready;
    end
  end
  // ****************************************
  // serial data input deserialiser
  // ****************************************
  reg sck_d1_q;
  reg [2:0] cnt_q;
  reg [7:0] byte_q;
  reg byte_v_q;
  wire sck_rise = sck_s_q[1] && !sck_d1_q;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sck_d1_q <= 1'b0;
      cnt_q <= 3'h0;
      byte_q <= 8'h0;
      byte_v_q <= 1'b0;
    end else begin
      sck_d1_q <= sck_s_q[1];
      byte_v_q <= 1'b0;
      if (sck_rise && boot_done_q && mode_q != `BMSI_MODE_SPI) begin
        byte_q <= {byte_q[6:0], sdi_s_q[1]};
        cnt_q <= cnt_q + 3'h1;
        byte_v_q <= cnt_q == 3'h7;
      end
    end
  end
  bmsi_fifo #(.W(`BMSI_FIFO_W), .D(`BMSI_FIFO_D), .AW(3)) u_fifo (
    .mclk(mclk),
    .rst(rst),
    // byte_q is complete in the cycle the valid strobe stands
    .in_data(byte_q),
    .in_valid(byte_v_q),
    .in_ready(fifo_in_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );
  // ****************************************
  // stream routing, midi, idle, termination
  // ****************************************
  reg prefix_q;
  reg [11:0] zrun_q;
  wire is_midi = mode_q == `BMSI_MODE_MIDI;
  assign fifo_pop = fifo_valid && (is_midi || stream_ready || !stream_valid_q);
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      prefix_q <= 1'b0;
      midi_byte_q <= 8'h0;
      midi_valid_q <= 1'b0;
      stream_byte_q <= 8'h0;
      stream_valid_q <= 1'b0;
      zrun_q <= 12'h0;
      stream_end_q <= 1'b0;
      idle_q <= 1'b1;
    end else begin
      midi_valid_q <= 1'b0;
      stream_end_q <= 1'b0;
      idle_q <= !fifo_valid && !stream_valid_q;
      if (is_midi && uart_valid) begin
        midi_byte_q <= uart_byte;
        midi_valid_q <= 1'b1;
      end else if (is_midi && fifo_pop) begin
        if (prefix_q) begin
          midi_byte_q <= fifo_data;
          midi_valid_q <= 1'b1;
          prefix_q <= 1'b0;
        end else begin
          prefix_q <= fifo_data == `BMSI_MIDI_PREFIX;
        end
      end
      if (!is_midi) begin
        if (fifo_pop) begin
          stream_byte_q <= fifo_data;
          stream_valid_q <= 1'b1;
          if (fifo_data != 8'h00) begin
            zrun_q <= 12'h0;
          end else if (zrun_q != `BMSI_ZERO_RUN) begin
            zrun_q <= zrun_q + 12'h1;
            stream_end_q <= zrun_q == `BMSI_ZERO_RUN - 12'h1;
          end
        end else if (stream_ready) begin
          stream_valid_q <= 1'b0;
        end
      end
    end
  end
  // ****************************************
  // header words, mute, converter enable
  // ****************************************
  reg ptr_hit_q;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      header_data_word0 <= 16'h0;
      header_data_word1 <= 16'h0;
      mute_q <= 1'b1;
      ptr_hit_q <= 1'b0;
      adc_on_q <= 1'b0;
    end else if (sw_reset) begin
      adc_on_q <= 1'b0;
      ptr_hit_q <= 1'b0;
      header_data_word0 <= 16'h0;
      header_data_word1 <= 16'h0;
      mute_q <= 1'b1;
    end else begin
      if (!decodable) begin
        header_data_word0 <= 16'h0;
        header_data_word1 <= 16'h0;
        mute_q <= 1'b1;
      end else begin
        mute_q <= 1'b0;
        if (stream_valid_q && stream_ready) begin
          header_data_word0 <= {header_data_word0[7:0], stream_byte_q};
          header_data_word1 <= header_data_word1 + 16'h1;
        end
      end
      if (reg_wr && !reg_sel_window) begin
        ptr_hit_q <= reg_wdata == `BMSI_PTR_ADC;
      end else if (reg_wr && reg_sel_window) begin
        if (ptr_hit_q && reg_wdata == `BMSI_WIN_ADC) begin
          adc_on_q <= 1'b1;
        end
        ptr_hit_q <= 1'b0;
      end
    end
  end
endmodule

// ==== testbench/bmsi_top_sva.sv ====
`timescale 1ns/1ps
module bmsi_top_sva (
  input wire mclk,
  input wire rst,
  input wire sw_reset,
  input wire decodable,
  input wire reg_wr,
  input wire reg_sel_window,
  input wire [15:0] reg_wdata,
  input wire boot_select_pin_a_o,
  input wire boot_select_pin_a_oe,
  input wire boot_select_pin_b_o,
  input wire boot_select_pin_b_oe,
  input wire [1:0] mode_q,
  input wire boot_done_q,
  input wire [15:0] sample_rate_q,
  input wire [3:0] clock_mult_q,
  input wire [15:0] uart_rate_q,
  input wire [1:0] spatial_q,
  input wire [15:0] header_data_word0,
  input wire [15:0] header_data_word1,
  input wire mute_q,
  input wire adc_on_q
);
  // ****
  // helpers
  // ****
  reg arm_q;
  reg pb_q;
  reg [5:0] hc_q;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      arm_q <= 1'b0;
      pb_q <= 1'b0;
      hc_q <= 6'h0;
    end else begin
      // any other write breaks the pointer-window pair
      if (reg_wr)
        arm_q <= !reg_sel_window && reg_wdata == 16'hc01e;
      pb_q <= boot_select_pin_b_o;
      hc_q <= (boot_select_pin_b_o != pb_q) ? 6'h0 : hc_q + 6'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_midi_setup:
    assert property (boot_done_q && mode_q == 2'h2 |-> sample_rate_q ==
      16'hac44 && clock_mult_q == 4'h8 && uart_rate_q == 16'h7a12)
    else $error("midi settings wrong");
  a_spatial_hold:
    assert property (boot_done_q && $past(boot_done_q) |-> $stable(spatial_q))
    else $error("spatial changed after boot");
  a_mode_hold:
    assert property (boot_done_q && $past(boot_done_q) |-> $stable(mode_q))
    else $error("mode changed after boot");
  a_no_data:
    assert property ((boot_done_q && mode_q == 2'h0 && !decodable) [*4] |->
      mute_q && header_data_word0 == 16'h0 && header_data_word1 == 16'h0)
    else $error("no data but not muted");
  a_adc_start:
    assert property (reg_wr && reg_sel_window && reg_wdata == 16'h0800 &&
      arm_q && !sw_reset |=> adc_on_q)
    else $error("converter not started");
  a_adc_off:
    assert property (sw_reset |=> !adc_on_q)
    else $error("converter on after soft reset");
  a_pins_free:
    assert property (mode_q != 2'h1 |->
      !boot_select_pin_a_oe && !boot_select_pin_b_oe)
    else $error("boot pins driven outside spi boot");
  a_sck_half:
    assert property (mode_q == 2'h1 && !boot_select_pin_a_o && pb_q &&
      !boot_select_pin_b_o |-> hc_q == 6'd25)
    else $error("spi clock high phase wrong");
endmodule
bind bmsi_top bmsi_top_sva bmsi_top_sva_inst (.mclk, .rst, .sw_reset,
  .decodable, .reg_wr, .reg_sel_window, .reg_wdata, .boot_select_pin_a_o,
  .boot_select_pin_a_oe, .boot_select_pin_b_o, .boot_select_pin_b_oe,
  .mode_q, .boot_done_q, .sample_rate_q, .clock_mult_q, .uart_rate_q,
  .spatial_q, .header_data_word0, .header_data_word1, .mute_q, .adc_on_q);

// ==== testbench/bmsi_eeprom_model.sv ====
`timescale 1ns/1ps
module bmsi_eeprom_model (
  input wire cs_n,
  input wire sck,
  input wire mosi,
  input wire bad,
  output reg miso
);
  integer n = 0;
  wire [23:0] img = {8'h50, 8'h26, 8'h48 ^ {7'h0, bad}};
  initial miso = 1'b0;
  always @(negedge cs_n) n = 0;
  always @(posedge sck) if (!cs_n) n = n + 1;
  // command and 16 address bits first; released line flips
  always @(negedge sck or posedge cs_n) begin
    if (cs_n)
      miso <= ~miso;
    else if (n >= 24 && n < 48)
      miso <= img[47 - n];
  end
endmodule

// ==== testbench/bmsi_top_tb.sv ====
`timescale 1ns/1ps
module bmsi_top_tb;
  reg mclk = 1'b0, rst = 1'b1, sw_reset = 1'b0, sa = 1'b0, sb = 1'b0;
  reg pc = 1'b0, general_pin_d = 1'b0, sdi_clk = 1'b0, bad = 1'b0;
  reg serial_data_input = 1'b0, uart_valid = 1'b0, decodable = 1'b0;
  reg reg_wr = 1'b0, reg_sel_window = 1'b0, stream_ready = 1'b0;
  reg [7:0] uart_byte = 8'h0, last_midi = 8'h0;
  reg [15:0] reg_wdata = 16'h0;
  integer mismatches = 0, cmp_count = 0, cyc = 0, i, j, k;
  wire boot_select_pin_a_o, boot_select_pin_a_oe, boot_select_pin_b_o;
  wire boot_select_pin_b_oe, data_request, boot_done_q, boot_fail_q, miso;
  wire midi_valid_q, stream_valid_q, mute_q, idle_q, stream_end_q, adc_on_q;
  wire [1:0] mode_q, spatial_q;
  wire [3:0] clock_mult_q;
  wire [7:0] midi_byte_q, stream_byte_q;
  wire [15:0] sample_rate_q, uart_rate_q, header_data_word0;
  wire [15:0] header_data_word1;
  // undriven boot pins fall back to their straps
  wire boot_select_pin_a_i = boot_select_pin_a_oe ? boot_select_pin_a_o : sa;
  wire boot_select_pin_b_i = boot_select_pin_b_oe ? boot_select_pin_b_o : sb;
  wire general_pin_c = boot_select_pin_a_oe ? miso : pc;
  always #2.5 mclk = ~mclk;
  bmsi_top bmsi_top_inst (.mclk, .rst, .sw_reset, .boot_select_pin_a_i,
    .boot_select_pin_a_o, .boot_select_pin_a_oe, .boot_select_pin_b_i,
    .boot_select_pin_b_o, .boot_select_pin_b_oe, .general_pin_c,
    .general_pin_d, .data_request, .sdi_clk, .serial_data_input, .uart_byte,
    .uart_valid, .decodable, .reg_wr, .reg_sel_window, .reg_wdata, .mode_q,
    .boot_done_q, .boot_fail_q, .sample_rate_q, .clock_mult_q, .uart_rate_q,
    .spatial_q, .midi_byte_q, .midi_valid_q, .stream_byte_q, .stream_valid_q,
    .stream_ready, .header_data_word0, .header_data_word1, .mute_q, .idle_q,
    .stream_end_q, .adc_on_q);
  bmsi_eeprom_model bmsi_eeprom_model_inst (.cs_n(boot_select_pin_a_i),
    .sck(boot_select_pin_b_i), .mosi(data_request), .bad, .miso);
  // one-cycle pulse, so latch it here
  always @(posedge mclk) if (midi_valid_q === 1'b1) last_midi <= midi_byte_q;
  // ****
  // tasks
  // ****
  task step(input integer n);
    repeat (n) @(posedge mclk);
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        mismatches = mismatches + 1;
      end
    end
  endtask
  task boot(input a, input b, input c);
    begin
      rst <= 1'b1;
      sa <= a;
      sb <= b;
      pc <= c;
      step(8);
      rst <= 1'b0;
      for (i = 0; i < 6000 && boot_done_q !== 1'b1; i = i + 1) step(1);
    end
  endtask
  task wr(input s, input [15:0] d);
    begin
      reg_sel_window <= s;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      step(1);
      reg_wr <= 1'b0;
      step(1);
    end
  endtask
  // link clock of 80 ns: 16 mclk periods, driven on mclk edges
  task sdi_byte(input [7:0] b);
    begin
      for (k = 7; k >= 0; k = k - 1) begin
        serial_data_input <= b[k];
        step(4);
        sdi_clk <= 1'b1;
        step(8);
        sdi_clk <= 1'b0;
        step(4);
      end
      serial_data_input <= ~b[0];
      step(1);
    end
  endtask
  task t_play;
    begin
      boot(1'b0, 1'b0, 1'b0);
      chk(mode_q, 2'h0);
      chk(boot_select_pin_a_oe, 1'b0);
      decodable <= 1'b1;
      step(3);
      decodable <= 1'b0;
      step(6);
      chk(header_data_word0, 16'h0);
      chk(header_data_word1, 16'h0);
      chk(mute_q, 1'b1);
      chk(idle_q, 1'b1);
      wr(1'b1, 16'h0800);
      step(2);
      chk(adc_on_q, 1'b0);
      wr(1'b0, 16'hc01e);
      wr(1'b1, 16'h0800);
      step(2);
      chk(adc_on_q, 1'b1);
      sw_reset <= 1'b1;
      step(1);
      sw_reset <= 1'b0;
      step(2);
      chk(adc_on_q, 1'b0);
      wr(1'b0, 16'hc01e);
      wr(1'b1, 16'h0800);
      // far side stalls until the buffer refuses
      for (j = 0; j < 10; j = j + 1) sdi_byte(8'ha0 + j[7:0]);
      step(8);
      chk(data_request, 1'b0);
      stream_ready <= 1'b1;
      chk(stream_byte_q, 8'ha0);
      step(80);
      chk(data_request, 1'b1);
      $display("test play done");
    end
  endtask
  task t_spi(input fail);
    begin
      bad <= fail;
      boot(1'b1, 1'b0, 1'b0);
      chk(boot_done_q, 1'b1);
      chk(mode_q, 2'h1);
      chk(boot_fail_q, fail);
      chk(adc_on_q, 1'b0);
      $display("test spi done");
    end
  endtask
  task t_midi;
    begin
      boot(1'b0, 1'b1, 1'b1);
      chk(mode_q, 2'h2);
      chk(sample_rate_q, 16'hac44);
      chk(clock_mult_q, 4'h8);
      chk(uart_rate_q, 16'h7a12);
      chk(spatial_q, 2'h1);
      pc <= 1'b0;
      general_pin_d <= 1'b1;
      uart_byte <= 8'h3c;
      uart_valid <= 1'b1;
      step(1);
      uart_valid <= 1'b0;
      step(10);
      chk(last_midi, 8'h3c);
      chk(spatial_q, 2'h1);
      sdi_byte(8'hff);
      sdi_byte(8'h5a);
      step(10);
      chk(last_midi, 8'h5a);
      $display("test midi done");
    end
  endtask
  task finish_test;
    begin
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      finish_test;
    end
  end
  initial begin
    t_play;
    t_spi(1'b0);
    t_spi(1'b1);
    t_midi;
    finish_test;
  end
endmodule
